// *** exec_params.svh ***
// Constants for the subtract, swap and table-read execution datapath
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define DATA_W 8
`define FILE_ADDR_W 6
`define FILE_DEPTH 64
`define PROG_W 14
`define PROG_ADDR_W 11
`define TPH_W 3
`define THD_W 6
`define NIB_LO_MSB 3
`define ACC_RESET 8'h00
`define TPH_RESET 3'h0
`define THD_RESET 6'h00
`define FILE_RESET 8'h00
`define TABLE_CYCLES 2
`endif

// *** exec_pkg.sv ***
// Types for the subtract, swap and table-read execution datapath
package exec_pkg;
	typedef enum logic [2:0] {
		op_none,
		op_reg_minus_acc,
		op_nibble_exchange,
		op_imm_minus_acc,
		op_program_table_read
	} op_type;
	typedef enum logic {
		st_idle,
		st_table_wait
	} phase_type;
endpackage : exec_pkg

// *** sub_unit.sv ***
// Eight-bit subtractor with zero, digit-carry and carry flags
`timescale 1ns/1ps
`include "exec_params.svh"
module sub_unit (
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	output logic [7:0] result,
	output logic zero,
	output logic digit_carry,
	output logic carry
);
	logic [4:0] low_sum;
	logic [8:0] full_sum;
	always_comb
	begin
		// Add the inverse plus one, carry out means no borrow
		low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
		full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
		result = full_sum[7:0];
		// [RULE7] digit carry and zero
		digit_carry = low_sum[4];
		zero = (full_sum[7:0] == 8'h00);
		carry = full_sum[8];
	end
endmodule : sub_unit

// *** exec_datapath.sv ***
// Execution datapath for subtract, nibble swap and program table read
`timescale 1ns/1ps
`include "exec_params.svh"
// Summary of operation
// [RULE1] Register minus accumulator in one cycle, updating zero, digit-carry, carry.
// [RULE2] Destination bit zero writes accumulator, one writes the file register.
// [RULE3] Nibble exchange swaps register halves, flags untouched, one cycle.
// [RULE4] Immediate minus accumulator into accumulator, flags updated, one cycle.
// [RULE5] Table read addresses {pointer high[2:0], acc}, low byte to acc, two cycles.
// [RULE6] Upper six bits of the fetched word go to table high data.
// [RULE7] Digit carry set without borrow from bit 3; zero on zero result.
module exec_datapath (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire exec_pkg::op_type op,
	input wire logic [5:0] file_addr,
	input wire logic dest_bit,
	input wire logic [7:0] imm,
	input wire logic [2:0] table_pointer_high,
	input wire logic [13:0] prog_data,
	output logic [10:0] prog_addr,
	output logic busy,
	output logic done,
	output logic [7:0] acc,
	output logic [5:0] table_high_data,
	output logic zero_flag,
	output logic digit_carry_flag,
	output logic carry_flag,
	output logic file_we,
	output logic [5:0] file_waddr,
	output logic [7:0] file_wdata
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		exec_pkg::phase_type phase;
		logic [7:0] acc;
		logic [5:0] thd;
		logic z;
		logic dc;
		logic c;
		logic [10:0] paddr;
		logic busy;
		logic done;
		logic we;
		logic [5:0] waddr;
		logic [7:0] wdata;
	} state_type;

	state_type cur;
	state_type next_cur;
	logic [7:0] file_mem [0:`FILE_DEPTH-1];
	logic [7:0] file_rd;
	logic [7:0] sub_a;
	logic [7:0] sub_res;
	logic sub_z;
	logic sub_dc;
	logic sub_c;

	assign file_rd = file_mem[file_addr];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] swap_nibbles(input logic [7:0] value);
		swap_nibbles = {value[3:0], value[7:4]};
	endfunction : swap_nibbles

	// ----------------------------------------
	// Subtractor
	// ----------------------------------------
	always_comb
	begin
		// Both subtracts share one subtractor, only the minuend differs
		sub_a = (op == exec_pkg::op_imm_minus_acc) ? imm : file_rd;
	end

	sub_unit u_sub (
		.minuend(sub_a),
		.subtrahend(cur.acc),
		.result(sub_res),
		.zero(sub_z),
		.digit_carry(sub_dc),
		.carry(sub_c)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.we = 1'b0;
		unique case (cur.phase)
			exec_pkg::st_idle:
			begin
				if (start)
				begin
					unique case (op)
						exec_pkg::op_reg_minus_acc:
						begin
							// [RULE1] flags from subtract
							next_cur.z = sub_z;
							next_cur.dc = sub_dc;
							next_cur.c = sub_c;
							next_cur.done = 1'b1;
							// [RULE2] destination steering
							if (dest_bit)
							begin
								next_cur.we = 1'b1;
								next_cur.waddr = file_addr;
								next_cur.wdata = sub_res;
							end
							else
								next_cur.acc = sub_res;
						end
						exec_pkg::op_nibble_exchange:
						begin
							// [RULE3] swap halves, flags kept
							next_cur.done = 1'b1;
							if (dest_bit)
							begin
								next_cur.we = 1'b1;
								next_cur.waddr = file_addr;
								next_cur.wdata = swap_nibbles(file_rd);
							end
							else
								next_cur.acc = swap_nibbles(file_rd);
						end
						exec_pkg::op_imm_minus_acc:
						begin
							// [RULE4] immediate subtract
							next_cur.acc = sub_res;
							next_cur.z = sub_z;
							next_cur.dc = sub_dc;
							next_cur.c = sub_c;
							next_cur.done = 1'b1;
						end
						exec_pkg::op_program_table_read:
						begin
							// [RULE5] form table address
							next_cur.paddr = {table_pointer_high, cur.acc};
							next_cur.busy = 1'b1;
							next_cur.phase = exec_pkg::st_table_wait;
						end
						default:
						begin
							next_cur.done = 1'b0;
						end
					endcase
				end
			end
			// Start is ignored here, a pending table read blocks new ops
			exec_pkg::st_table_wait:
			begin
				// Program word settles from prog_addr during this cycle
				// [RULE5] low byte on second cycle
				next_cur.acc = prog_data[7:0];
				// [RULE6] upper six bits
				next_cur.thd = prog_data[13:8];
				next_cur.busy = 1'b0;
				next_cur.done = 1'b1;
				next_cur.phase = exec_pkg::st_idle;
			end
		endcase
		// Reset wins over any op issued in the same cycle
		if (srst)
		begin
			next_cur.phase = exec_pkg::st_idle;
			next_cur.acc = `ACC_RESET;
			next_cur.thd = `THD_RESET;
			next_cur.z = 1'b0;
			next_cur.dc = 1'b0;
			next_cur.c = 1'b0;
			next_cur.paddr = 11'h000;
			next_cur.busy = 1'b0;
			next_cur.done = 1'b0;
			next_cur.we = 1'b0;
			next_cur.waddr = 6'h00;
			next_cur.wdata = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		cur <= next_cur;
	end

	// ----------------------------------------
	// File register array
	// ----------------------------------------
	// Cleared on reset so no entry is ever read unknown
	generate
		for (genvar i = 0; i < `FILE_DEPTH; i = i + 1)
		begin : g_file
			always_ff @(posedge clk)
			begin
				if (srst)
					file_mem[i] <= `FILE_RESET;
				else if (next_cur.we && (next_cur.waddr == 6'(i)))
					file_mem[i] <= next_cur.wdata;
			end
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prog_addr = cur.paddr;
	assign busy = cur.busy;
	assign done = cur.done;
	assign acc = cur.acc;
	assign table_high_data = cur.thd;
	assign zero_flag = cur.z;
	assign digit_carry_flag = cur.dc;
	assign carry_flag = cur.c;
	assign file_we = cur.we;
	assign file_waddr = cur.waddr;
	assign file_wdata = cur.wdata;
endmodule : exec_datapath

// *** exec_checker_assertions.sv ***
// Assertions for the execution datapath
`timescale 1ns/1ps
module exec_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire exec_pkg::op_type op,
	input wire logic [5:0] file_addr,
	input wire logic dest_bit,
	input wire logic [7:0] imm,
	input wire logic [2:0] table_pointer_high,
	input wire logic [13:0] prog_data,
	input wire logic [10:0] prog_addr,
	input wire logic busy,
	input wire logic done,
	input wire logic [7:0] acc,
	input wire logic [5:0] table_high_data,
	input wire logic zero_flag,
	input wire logic digit_carry_flag,
	input wire logic carry_flag,
	input wire logic file_we,
	input wire logic [5:0] file_waddr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	wire logic go = start && !busy;
	wire logic tbl = go && op == exec_pkg::op_program_table_read;
	wire logic sub = go && op == exec_pkg::op_imm_minus_acc;
	wire logic swp = go && op == exec_pkg::op_nibble_exchange;
	wire logic fop = swp || (go && op == exec_pkg::op_reg_minus_acc);
	a_table_timing: assert property (tbl |=> busy ##1 done && !busy)
		else $error("table read timing");
	a_table_addr: assert property (tbl |=> prog_addr == {$past(table_pointer_high), $past(acc)})
		else $error("table address");
	a_table_data: assert property (busy |=> acc == $past(prog_data[7:0])
		&& table_high_data == $past(prog_data[13:8])) else $error("table data");
	a_imm_result: assert property (sub |=> done && acc == $past(imm) - $past(acc))
		else $error("immediate subtract");
	a_sub_flags: assert property (sub |=> zero_flag == (acc == 8'h00)
		&& carry_flag == ($past(imm) >= $past(acc))
		&& digit_carry_flag == ($past(imm[3:0]) >= $past(acc[3:0]))) else $error("flags");
	a_swap_flags: assert property (swp |=> $stable(zero_flag) && $stable(carry_flag)
		&& $stable(digit_carry_flag) && done) else $error("swap flags");
	a_dest_file: assert property (fop && dest_bit |=> file_we && $stable(acc)
		&& file_waddr == $past(file_addr)) else $error("file write");
	a_dest_acc: assert property (fop && !dest_bit |=> !file_we && done)
		else $error("acc destination");
endmodule : exec_checker
bind exec_datapath exec_checker chk_inst (
	.clk(clk),
	.srst(srst),
	.start(start),
	.op(op),
	.file_addr(file_addr),
	.dest_bit(dest_bit),
	.imm(imm),
	.table_pointer_high(table_pointer_high),
	.prog_data(prog_data),
	.prog_addr(prog_addr),
	.busy(busy),
	.done(done),
	.acc(acc),
	.table_high_data(table_high_data),
	.zero_flag(zero_flag),
	.digit_carry_flag(digit_carry_flag),
	.carry_flag(carry_flag),
	.file_we(file_we),
	.file_waddr(file_waddr)
);

// *** testbench.sv ***
// Directed bench for the execution datapath
`timescale 1ns/1ps
module testbench;
	logic clk = 0;
	logic srst = 1;
	logic start = 0;
	exec_pkg::op_type op = exec_pkg::op_none;
	logic [5:0] file_addr = 6'h00;
	logic dest_bit = 0;
	logic [7:0] imm = 8'h00;
	logic [2:0] table_pointer_high = 3'h2;
	logic [10:0] prog_addr;
	wire logic [13:0] prog_data = (prog_addr == 11'h234) ? 14'h35aa : 14'h0155;
	logic busy, done, zero_flag, digit_carry_flag, carry_flag, file_we;
	logic [7:0] acc, file_wdata;
	logic [5:0] table_high_data, file_waddr;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	exec_datapath uut (
		.clk(clk),
		.srst(srst),
		.start(start),
		.op(op),
		.file_addr(file_addr),
		.dest_bit(dest_bit),
		.imm(imm),
		.table_pointer_high(table_pointer_high),
		.prog_data(prog_data),
		.prog_addr(prog_addr),
		.busy(busy),
		.done(done),
		.acc(acc),
		.table_high_data(table_high_data),
		.zero_flag(zero_flag),
		.digit_carry_flag(digit_carry_flag),
		.carry_flag(carry_flag),
		.file_we(file_we),
		.file_waddr(file_waddr),
		.file_wdata(file_wdata)
	);
	initial
	begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 500)
		begin
			num_errors++;
			summarize();
		end
	end
	task summarize();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task issue(input exec_pkg::op_type o, input logic [7:0] v, input logic [5:0] a, input logic d);
		@(negedge clk);
		start = 1;
		op = o;
		imm = v;
		file_addr = a;
		dest_bit = d;
		@(negedge clk);
		start = 0;
	endtask : issue
	initial
	begin
		repeat (4) @(negedge clk);
		srst = 0;
		chk(acc, 8'h00);
		issue(exec_pkg::op_imm_minus_acc, 8'h05, 6'h00, 0);
		chk(acc, 8'h05);
		issue(exec_pkg::op_imm_minus_acc, 8'h06, 6'h00, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b011, 8'h01});
		issue(exec_pkg::op_imm_minus_acc, 8'h00, 6'h00, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b000, 8'hff});
		issue(exec_pkg::op_imm_minus_acc, 8'hff, 6'h00, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b111, 8'h00});
		issue(exec_pkg::op_imm_minus_acc, 8'h5b, 6'h00, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b011, 8'h5b});
		// File register 63 starts at zero: 0x00 - 0x5b written back
		issue(exec_pkg::op_reg_minus_acc, 8'h00, 6'h3f, 1);
		chk({zero_flag, digit_carry_flag, carry_flag}, 3'b000);
		chk({file_we, file_waddr, file_wdata}, {1'b1, 6'h3f, 8'ha5});
		chk({done, acc}, {1'b1, 8'h5b});
		issue(exec_pkg::op_nibble_exchange, 8'h00, 6'h3f, 0);
		chk({zero_flag, digit_carry_flag, carry_flag}, 3'b000);
		chk({done, file_we, acc}, {2'b10, 8'h5a});
		issue(exec_pkg::op_reg_minus_acc, 8'h00, 6'h3f, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b001, 8'h4b});
		chk(file_we, 1'b0);
		issue(exec_pkg::op_nibble_exchange, 8'h00, 6'h3f, 1);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b001, 8'h4b});
		chk({file_we, file_waddr, file_wdata}, {1'b1, 6'h3f, 8'h5a});
		issue(exec_pkg::op_imm_minus_acc, 8'h7f, 6'h00, 0);
		chk({zero_flag, digit_carry_flag, carry_flag, acc}, {3'b011, 8'h34});
		issue(exec_pkg::op_program_table_read, 8'h00, 6'h00, 0);
		chk({busy, done, prog_addr}, {2'b10, 11'h234});
		@(negedge clk);
		chk({busy, done, table_high_data, acc}, {2'b01, 6'h35, 8'haa});
		issue(exec_pkg::op_nibble_exchange, 8'h00, 6'h3f, 0);
		chk({done, file_we, acc}, {2'b10, 8'ha5});
		summarize();
	end
endmodule : testbench
